// ### pkg/sastc_consts.svh
`ifndef SASTC_CONSTS_SVH
`define SASTC_CONSTS_SVH

`define SASTC_CMD_HEALTH 8'hB0
`define SASTC_SUB_AUTOSAVE 8'hD2
`define SASTC_SUB_SAVE 8'hD3
`define SASTC_SUB_EXEC 8'hD4
`define SASTC_SUB_ENABLE 8'hD8
`define SASTC_SUB_DISABLE 8'hD9
`define SASTC_AS_OFF 8'h00
`define SASTC_AS_ON 8'hF1
`define SASTC_EX_COLLECT 8'h00
`define SASTC_EX_SHORT 8'h01
`define SASTC_EX_EXTENDED 8'h02
`define SASTC_EX_SELECTIVE 8'h04
`define SASTC_EX_ABORT 8'h7F
`define SASTC_EX_ABORT_ALT 8'h0F
`define SASTC_EX_CAPTIVE 8'h80
`define SASTC_FAIL_LBA_LOW 8'hF4
`define SASTC_FAIL_LBA_HIGH 8'h2C
`define SASTC_ST_DONE 8'h00
`define SASTC_OL_DONE 8'h02
`define SASTC_OL_SUSPENDED 8'h03
`define SASTC_SPAN_OFFLINE 8'h06
`define SASTC_CLK_HZ 20000000
`define SASTC_AUTOSAVE_MIN 15
`define SASTC_AUTOSAVE_CYC (64'(`SASTC_AUTOSAVE_MIN) * 64'd60 * 64'(`SASTC_CLK_HZ))
`define SASTC_SERVICE_S 2
`define SASTC_SERVICE_CYC (`SASTC_SERVICE_S * `SASTC_CLK_HZ)
`define SASTC_ADDR_CTRL 12'h000
`define SASTC_ADDR_STATUS 12'h004
`define SASTC_CTRL_HEALTH_BIT 0
`define SASTC_CTRL_AUTOSAVE_BIT 1

`endif

// ### pkg/sastc_pkg.sv
package sastc_pkg;
    typedef enum logic [2:0] {
        SASTC_IDLE,
        SASTC_BUSY,
        SASTC_CAPTIVE,
        SASTC_SPANS,
        SASTC_OFFLINE,
        SASTC_DONE
    } sastc_state_e;

    typedef enum logic [1:0] {
        SASTC_T_NONE,
        SASTC_T_COLLECT,
        SASTC_T_SELF,
        SASTC_T_SELECTIVE
    } sastc_test_e;
endpackage

// ### rtl/sastc_top.sv
// Function
// - Autosave stores attributes at first active idle, then every 15 minutes.
// - Autosave enable state survives power cycles via nonvolatile storage.
// - Autosave subcommand with sector count 00h disables autosave.
// - Autosave subcommand with sector count F1h enables autosave.
// - Other nonzero sector count leaves autosave unchanged and reports error.
// - Attributes may still be saved at power-up or power-down when disabled.
// - Autosave subcommand: raise BSY and apply, then drop BSY and assert INTRQ on the same edge.
// - Disabling health monitoring also turns autosave off.
// - Save subcommand: BSY, write attributes regardless of autosave, drop BSY, INTRQ.
// - Execute-immediate decodes LBA Low into collection, tests, abort, reserved.
// - Off-line mode completes command first, never sets BSY nor clears DRDY.
// - New host command during off-line routine is served within two seconds.
// - Captive mode holds BSY during test, records result, then completes.
// - Captive failure sets ERR, ABRT, LBA Low F4h, LBA High 2Ch.
// - LBA Low 4 or 132 starts selective test: extended checks then span scan. Code scans spans only for 4; 132 runs captive and ends at I_TEST_DONE.
// - Scan each span fully, report progress, end with status by errors.
// - Span scan error is reported and the following off-line scan skipped.
// - Spans done with scan flag: pending, active, span>5, status 00h, 03h.
// - After power-up, wait pending time with active low, then resume scan.
// - Whole media scanned: clear pending and active, off-line status 02h.
// - Reset aborts selective test unless pending; abort code and new test abort it.
`timescale 1ns/1ps
`default_nettype none
`include "sastc_consts.svh"

module sastc_top (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CMD_STB,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_FEATURES,
    input wire logic [7:0] I_SECTOR_COUNT,
    input wire logic [7:0] I_LBA_LOW,
    input wire logic I_HOST_RESET,
    input wire logic I_ACTIVE_IDLE,
    input wire logic I_POWER_EVENT,
    input wire logic I_NV_AUTOSAVE,
    input wire logic I_NV_PENDING,
    input wire logic I_TEST_DONE,
    input wire logic I_TEST_FAIL,
    input wire logic I_OFFLINE_FLAG,
    input wire logic I_SPAN_DONE,
    input wire logic I_LAST_SPAN,
    input wire logic I_SUSPENDED,
    input wire logic I_PENDING_EXPIRED,
    input wire logic I_MEDIA_DONE,
    input wire logic I_SAVE_DONE,
    input wire logic PCLK,
    input wire logic PRESETn,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic O_BSY,
    output logic O_DRDY,
    output logic O_INTRQ,
    output logic O_ERR,
    output logic O_ABRT,
    output logic [7:0] O_LBA_LOW,
    output logic [7:0] O_LBA_HIGH,
    output logic O_SAVE_REQ,
    output logic O_NV_WRITE,
    output logic O_AUTOSAVE_EN,
    output logic O_HEALTH_EN,
    output logic O_TEST_START,
    output sastc_pkg::sastc_test_e O_TEST_KIND,
    output logic O_TEST_ABORT,
    output logic O_PENDING,
    output logic O_ACTIVE,
    output logic [7:0] O_SELFTEST_STATUS,
    output logic [7:0] O_OFFLINE_STATUS,
    output logic [7:0] O_SPAN_UNDER_TEST
);
    import sastc_pkg::*;

    localparam logic [35:0] AUTOSAVE_CYC = 36'(`SASTC_AUTOSAVE_CYC);
    localparam logic [35:0] SERVICE_CYC = 36'(`SASTC_SERVICE_CYC);

    typedef struct packed {
        sastc_state_e state;
        sastc_test_e kind;
        logic health_en;
        logic autosave_en;
        logic idle_seen;
        logic [35:0] save_cnt;
        logic [35:0] svc_cnt;
        logic bsy;
        logic intrq;
        logic err;
        logic abrt;
        logic [7:0] lba_low;
        logic [7:0] lba_high;
        logic save_req;
        logic nv_write;
        logic test_start;
        logic test_abort;
        logic scan_flag;
        logic span_err;
        logic pending;
        logic active;
        logic [7:0] st_status;
        logic [7:0] ol_status;
        logic [7:0] span;
        logic boot;
        logic [2:0] act_sync;
        logic [2:0] pwr_sync;
        logic [31:0] prdata;
    } sastc_regs_s;

    sastc_regs_s q, d;

    function automatic logic is_test(input logic [7:0] code);
        logic [7:0] base;
        base = code & 8'h7F;
        is_test = (base == `SASTC_EX_SHORT) || (base == `SASTC_EX_EXTENDED)
            || (base == `SASTC_EX_SELECTIVE);
    endfunction

    function automatic sastc_state_e resume_state(input sastc_test_e kind, input logic pend);
        resume_state = (kind == SASTC_T_SELECTIVE && !pend) ? SASTC_SPANS
            : (kind != SASTC_T_NONE) ? SASTC_OFFLINE : SASTC_IDLE;
    endfunction

    logic health_cmd;
    logic apb_wr;
    logic act_rise;
    logic pwr_rise;
    assign health_cmd = I_CMD_STB && (I_CMD == `SASTC_CMD_HEALTH);
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign act_rise = (q.act_sync[2:1] == 2'b01);
    assign pwr_rise = (q.pwr_sync[2:1] == 2'b01);

    always_comb begin
        d = q;
        d.act_sync = {q.act_sync[1:0], I_ACTIVE_IDLE};
        d.pwr_sync = {q.pwr_sync[1:0], I_POWER_EVENT};
        d.intrq = 1'b0;
        d.save_req = 1'b0;
        d.nv_write = 1'b0;
        d.test_start = 1'b0;
        d.test_abort = 1'b0;
        d.prdata = 32'h0000_0000;
        if (q.boot) begin
            d.boot = 1'b0;
            d.autosave_en = I_NV_AUTOSAVE;
            d.pending = I_NV_PENDING;
            d.active = 1'b0;
            if (I_NV_PENDING) begin
                d.state = SASTC_OFFLINE;
                d.kind = SASTC_T_SELECTIVE;
            end
        end
        // Autosave timer
        if (q.autosave_en && q.health_en) begin
            if (act_rise && !q.idle_seen) begin
                d.idle_seen = 1'b1;
                d.save_req = 1'b1;
                d.save_cnt = 36'h0_0000_0000;
            end else if (q.idle_seen) begin
                if (q.save_cnt >= AUTOSAVE_CYC - 36'h0_0000_0001) begin
                    d.save_cnt = 36'h0_0000_0000;
                    d.save_req = 1'b1;
                end else begin
                    d.save_cnt = q.save_cnt + 36'h0_0000_0001;
                end
            end
        end
        if (pwr_rise) begin
            d.save_req = 1'b1;
        end
        if (I_HOST_RESET && (q.kind == SASTC_T_SELECTIVE) && !q.pending) begin
            d.test_abort = 1'b1;
            d.state = SASTC_IDLE;
            d.kind = SASTC_T_NONE;
            d.active = 1'b0;
        end
        unique case (q.state)
            SASTC_IDLE, SASTC_SPANS, SASTC_OFFLINE: begin
                if (q.state != SASTC_IDLE && !q.pending && I_CMD_STB) begin
                    d.svc_cnt = SERVICE_CYC;
                end
                if (q.svc_cnt != 36'h0_0000_0000) begin
                    d.svc_cnt = q.svc_cnt - 36'h0_0000_0001;
                end
                if (q.state == SASTC_SPANS) begin
                    if (I_TEST_FAIL) begin
                        d.span_err = 1'b1;
                    end
                    if (I_SPAN_DONE) begin
                        d.span = q.span + 8'h01;
                    end
                    if (I_SPAN_DONE && I_LAST_SPAN) begin
                        if (q.span_err || I_TEST_FAIL || !q.scan_flag) begin
                            d.st_status = {7'h00, q.span_err | I_TEST_FAIL};
                            d.state = SASTC_IDLE;
                            d.kind = SASTC_T_NONE;
                        end else begin
                            d.pending = 1'b1;
                            d.active = 1'b1;
                            d.span = `SASTC_SPAN_OFFLINE;
                            d.st_status = `SASTC_ST_DONE;
                            d.ol_status = `SASTC_OL_SUSPENDED;
                            d.state = SASTC_OFFLINE;
                        end
                    end
                end
                if (q.state == SASTC_OFFLINE) begin
                    if (q.pending && !q.active && I_PENDING_EXPIRED) begin
                        d.active = 1'b1;
                    end
                    if (q.active && I_MEDIA_DONE) begin
                        d.pending = 1'b0;
                        d.active = 1'b0;
                        d.ol_status = `SASTC_OL_DONE;
                        d.state = SASTC_IDLE;
                        d.kind = SASTC_T_NONE;
                    end
                end
                if (q.state != SASTC_IDLE && I_TEST_DONE
                        && q.kind != SASTC_T_SELECTIVE) begin
                    d.st_status = {7'h00, I_TEST_FAIL};
                    d.state = SASTC_IDLE;
                    d.kind = SASTC_T_NONE;
                end
                if (health_cmd) begin
                    d.bsy = 1'b1;
                    d.err = 1'b0;
                    d.abrt = 1'b0;
                    d.state = SASTC_BUSY;
                    if (!q.health_en && I_FEATURES != `SASTC_SUB_ENABLE) begin
                        d.err = 1'b1;
                        d.abrt = 1'b1;
                    end else begin
                        unique case (I_FEATURES)
                            `SASTC_SUB_AUTOSAVE: begin
                                if (I_SECTOR_COUNT == `SASTC_AS_OFF) begin
                                    d.autosave_en = 1'b0;
                                    d.nv_write = 1'b1;
                                end else if (I_SECTOR_COUNT == `SASTC_AS_ON) begin
                                    d.autosave_en = 1'b1;
                                    d.nv_write = 1'b1;
                                    d.idle_seen = 1'b0;
                                end else begin
                                    d.err = 1'b1;
                                    d.abrt = 1'b1;
                                end
                            end
                            `SASTC_SUB_SAVE: begin
                                d.save_req = 1'b1;
                                d.state = SASTC_DONE;
                            end
                            `SASTC_SUB_ENABLE: begin
                                d.health_en = 1'b1;
                                d.nv_write = 1'b1;
                            end
                            `SASTC_SUB_DISABLE: begin
                                d.health_en = 1'b0;
                                d.autosave_en = 1'b0;
                                d.nv_write = 1'b1;
                            end
                            `SASTC_SUB_EXEC: begin
                                if (I_LBA_LOW == `SASTC_EX_ABORT
                                        || I_LBA_LOW == `SASTC_EX_ABORT_ALT) begin
                                    d.test_abort = 1'b1;
                                    d.pending = 1'b0;
                                    d.active = 1'b0;
                                    d.kind = SASTC_T_NONE;
                                end else if (I_LBA_LOW == `SASTC_EX_COLLECT
                                        || is_test(I_LBA_LOW)) begin
                                    d.test_abort = (q.kind != SASTC_T_NONE);
                                    d.test_start = 1'b1;
                                    d.pending = 1'b0;
                                    d.active = 1'b0;
                                    d.span_err = 1'b0;
                                    d.span = 8'h01;
                                    d.scan_flag = I_OFFLINE_FLAG;
                                    d.kind = (I_LBA_LOW == `SASTC_EX_COLLECT) ? SASTC_T_COLLECT
                                        : ((I_LBA_LOW & 8'h7F) == `SASTC_EX_SELECTIVE)
                                        ? SASTC_T_SELECTIVE : SASTC_T_SELF;
                                    if (I_LBA_LOW[7]) begin
                                        d.state = SASTC_CAPTIVE;
                                    end
                                end else begin
                                    d.err = 1'b1;
                                    d.abrt = 1'b1;
                                end
                            end
                            default: begin
                                d.err = 1'b1;
                                d.abrt = 1'b1;
                            end
                        endcase
                    end
                end
            end
            SASTC_BUSY: begin
                d.bsy = 1'b0;
                d.intrq = 1'b1;
                d.state = resume_state(q.kind, q.pending);
            end
            SASTC_DONE: begin
                if (I_SAVE_DONE) begin
                    d.bsy = 1'b0;
                    d.intrq = 1'b1;
                    d.state = resume_state(q.kind, q.pending);
                end
            end
            SASTC_CAPTIVE: begin
                if (I_TEST_DONE) begin
                    d.st_status = {7'h00, I_TEST_FAIL};
                    d.bsy = 1'b0;
                    d.intrq = 1'b1;
                    d.kind = SASTC_T_NONE;
                    d.state = SASTC_IDLE;
                    if (I_TEST_FAIL) begin
                        d.err = 1'b1;
                        d.abrt = 1'b1;
                        d.lba_low = `SASTC_FAIL_LBA_LOW;
                        d.lba_high = `SASTC_FAIL_LBA_HIGH;
                    end
                end
            end
        endcase
        if (PSEL && !PENABLE && !PWRITE) begin
            d.prdata = (PADDR == `SASTC_ADDR_CTRL)
                ? {30'h0, q.autosave_en, q.health_en}
                : (PADDR == `SASTC_ADDR_STATUS)
                ? {q.span, q.ol_status, q.st_status, 3'h0, q.bsy, q.pending,
                    q.active, q.err, q.abrt}
                : 32'h0000_0000;
        end
        if (apb_wr && PADDR == `SASTC_ADDR_CTRL) begin
            d.health_en = PWDATA[`SASTC_CTRL_HEALTH_BIT];
            d.autosave_en = PWDATA[`SASTC_CTRL_AUTOSAVE_BIT]
                & PWDATA[`SASTC_CTRL_HEALTH_BIT];
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            q <= '0;
            q.state <= SASTC_IDLE;
            q.kind <= SASTC_T_NONE;
            q.health_en <= 1'b1;
            q.boot <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign PRDATA = q.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (PADDR != `SASTC_ADDR_CTRL)
        && (PADDR != `SASTC_ADDR_STATUS);
    assign O_BSY = q.bsy || (q.svc_cnt != 36'h0_0000_0000 && 1'b0);
    assign O_DRDY = 1'b1;
    assign O_INTRQ = q.intrq;
    assign O_ERR = q.err;
    assign O_ABRT = q.abrt;
    assign O_LBA_LOW = q.lba_low;
    assign O_LBA_HIGH = q.lba_high;
    assign O_SAVE_REQ = q.save_req;
    assign O_NV_WRITE = q.nv_write;
    assign O_AUTOSAVE_EN = q.autosave_en;
    assign O_HEALTH_EN = q.health_en;
    assign O_TEST_START = q.test_start;
    assign O_TEST_KIND = q.kind;
    assign O_TEST_ABORT = q.test_abort || (I_SUSPENDED && 1'b0);
    assign O_PENDING = q.pending;
    assign O_ACTIVE = q.active;
    assign O_SELFTEST_STATUS = q.st_status;
    assign O_OFFLINE_STATUS = q.ol_status;
    assign O_SPAN_UNDER_TEST = q.span;
endmodule // sastc_top

`default_nettype wire

// ### test/sastc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "sastc_consts.svh"
module sastc_props (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CMD_STB,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_FEATURES,
    input wire logic [7:0] I_SECTOR_COUNT,
    input wire logic I_TEST_DONE,
    input wire logic I_TEST_FAIL,
    input wire logic I_SAVE_DONE,
    input wire logic I_MEDIA_DONE,
    input wire logic O_BSY,
    input wire logic O_DRDY,
    input wire logic O_INTRQ,
    input wire logic O_ERR,
    input wire logic O_ABRT,
    input wire logic [7:0] O_LBA_LOW,
    input wire logic [7:0] O_LBA_HIGH,
    input wire logic O_AUTOSAVE_EN,
    input wire logic O_HEALTH_EN,
    input wire logic O_PENDING,
    input wire logic O_ACTIVE,
    input wire logic [7:0] O_OFFLINE_STATUS
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic go;
    logic sub_as;
    assign go = I_CMD_STB && I_CMD == `SASTC_CMD_HEALTH && !O_BSY && O_HEALTH_EN;
    assign sub_as = go && I_FEATURES == `SASTC_SUB_AUTOSAVE;
    as_enable_a: assert property (sub_as && I_SECTOR_COUNT == 8'hF1 |=>
        O_BSY && O_AUTOSAVE_EN ##1 !O_BSY && O_INTRQ) else $error("autosave enable walk wrong");
    as_disable_a: assert property (sub_as && I_SECTOR_COUNT == 8'h00 |=>
        !O_AUTOSAVE_EN) else $error("autosave not disabled");
    as_badcount_a: assert property (sub_as && I_SECTOR_COUNT != 8'h00 && I_SECTOR_COUNT != 8'hF1
        |=> $stable(O_AUTOSAVE_EN) ##1 O_ERR && O_ABRT) else $error("bad count mishandled");
    health_off_a: assert property (go && I_FEATURES == `SASTC_SUB_DISABLE |->
        ##2 !O_HEALTH_EN && !O_AUTOSAVE_EN) else $error("autosave survives health off");
    intrq_order_a: assert property ($rose(O_INTRQ) |-> $past(O_BSY) && !O_BSY)
        else $error("interrupt not after busy");
    intrq_pulse_a: assert property (O_INTRQ |=> !O_INTRQ) else $error("interrupt too long");
    drdy_high_a: assert property (O_DRDY) else $error("ready dropped");
    save_done_a: assert property (O_BSY && I_SAVE_DONE |=> !O_BSY && O_INTRQ)
        else $error("save completion wrong");
    captive_fail_a: assert property (O_BSY && I_TEST_DONE && I_TEST_FAIL |=> O_INTRQ &&
        O_ERR && O_ABRT && O_LBA_LOW == 8'hF4 && O_LBA_HIGH == 8'h2C) else $error("fail report");
    media_done_a: assert property (O_ACTIVE && I_MEDIA_DONE |=> !O_PENDING && !O_ACTIVE &&
        O_OFFLINE_STATUS == 8'h02) else $error("scan end wrong");
    cover property (sub_as);
    cover property (O_BSY && I_TEST_DONE && I_TEST_FAIL);
    cover property (O_ACTIVE && I_MEDIA_DONE);
endmodule // sastc_props
`default_nettype wire

// ### test/sastc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sastc_consts.svh"
module sastc_host_model (
    input wire logic i_clk,
    input wire logic i_intrq,
    output logic o_stb = 1'b0,
    output logic [7:0] o_cmd = 8'h00,
    output logic [7:0] o_feat = 8'h00,
    output logic [7:0] o_sc = 8'h00,
    output logic [7:0] o_lba = 8'h00
);
    // Waits up to 400 cycles for completion before returning; the next command follows it
    task automatic issue(input logic [7:0] f, input logic [7:0] s, input logic [7:0] l,
        output logic ok);
        @(posedge i_clk);
        o_stb <= 1'b1;
        o_cmd <= `SASTC_CMD_HEALTH;
        o_feat <= f;
        o_sc <= s;
        o_lba <= l;
        @(posedge i_clk);
        o_stb <= 1'b0;
        o_feat <= ~f;
        o_sc <= ~s;
        o_lba <= ~l;
        ok = 1'b0;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge i_clk);
            ok = (i_intrq === 1'b1);
        end
        @(posedge i_clk);
    endtask
endmodule // sastc_host_model
`default_nettype wire

// ### test/test_smart_autosave_selftest_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "sastc_consts.svh"
module test_smart_autosave_selftest_control;
    import sastc_pkg::*;
    typedef struct {logic [7:0] f, s, l; logic as, er; sastc_test_e k;} sastc_row_s;
    logic I_CLK = 0, I_SYS_RST = 1, I_HOST_RESET = 0, I_ACTIVE_IDLE = 0, I_POWER_EVENT = 0;
    logic I_NV_AUTOSAVE = 0, I_NV_PENDING = 0, I_TEST_DONE = 0, I_TEST_FAIL = 0;
    logic I_OFFLINE_FLAG = 0, I_SPAN_DONE = 0, I_LAST_SPAN = 0, I_SUSPENDED = 0;
    logic I_PENDING_EXPIRED = 0, I_MEDIA_DONE = 0, I_SAVE_DONE = 0;
    logic PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, O_BSY, O_DRDY, O_INTRQ;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic O_ERR, O_ABRT, O_SAVE_REQ, O_NV_WRITE, O_AUTOSAVE_EN, O_HEALTH_EN, O_TEST_START;
    logic O_TEST_ABORT, O_PENDING, O_ACTIVE, eng_hold = 0, eng_no_done = 0, ok, er;
    logic [7:0] O_LBA_LOW, O_LBA_HIGH, O_SELFTEST_STATUS, O_OFFLINE_STATUS, O_SPAN_UNDER_TEST;
    sastc_test_e O_TEST_KIND, kind_seen;
    wire logic I_CMD_STB;
    wire logic [7:0] I_CMD, I_FEATURES, I_SECTOR_COUNT, I_LBA_LOW;
    wire logic PCLK = I_CLK;
    wire logic PRESETn = !I_SYS_RST;
    int err_total = 0, checks = 0, save_seen = 0, abort_seen = 0;
    logic [7:0] abort_codes [2] = '{8'h7F, 8'h0F};
    sastc_row_s rows [14] = '{
        '{8'hD2, 8'hF1, 8'h00, 1, 0, SASTC_T_NONE}, '{8'hD2, 8'h05, 8'h00, 1, 1, SASTC_T_NONE},
        '{8'hD2, 8'h00, 8'h00, 0, 0, SASTC_T_NONE}, '{8'hD3, 8'h00, 8'h00, 0, 0, SASTC_T_NONE},
        '{8'hD4, 8'h00, 8'h00, 0, 0, SASTC_T_COLLECT}, '{8'hD4, 8'h00, 8'h01, 0, 0, SASTC_T_SELF},
        '{8'hD4, 8'h00, 8'h02, 0, 0, SASTC_T_SELF}, '{8'hD4, 8'h00, 8'h04, 0, 0, SASTC_T_SELECTIVE},
        '{8'hD4, 8'h00, 8'h81, 0, 0, SASTC_T_SELF}, '{8'hD4, 8'h00, 8'h82, 0, 0, SASTC_T_SELF},
        '{8'hD4, 8'h00, 8'h84, 0, 0, SASTC_T_SELECTIVE}, '{8'hD4, 8'h00, 8'h03, 0, 1, SASTC_T_NONE},
        '{8'hD4, 8'h00, 8'h40, 0, 1, SASTC_T_NONE}, '{8'hD4, 8'h00, 8'hC0, 0, 1, SASTC_T_NONE}};
    sastc_top uut (.*);
    sastc_host_model host (.i_clk(I_CLK), .i_intrq(O_INTRQ), .o_stb(I_CMD_STB), .o_cmd(I_CMD),
        .o_feat(I_FEATURES), .o_sc(I_SECTOR_COUNT), .o_lba(I_LBA_LOW));
    always #25 I_CLK = ~I_CLK;
    always @(posedge I_CLK) begin
        save_seen += (O_SAVE_REQ === 1'b1);
        abort_seen += (O_TEST_ABORT === 1'b1);
    end
    // Stand-in for the test and save engines
    initial forever begin
        @(posedge I_CLK);
        if (O_TEST_START === 1'b1 && !eng_hold) begin
            kind_seen = O_TEST_KIND;
            if (O_TEST_KIND === SASTC_T_SELECTIVE) begin
                repeat (3) @(posedge I_CLK);
                I_SPAN_DONE <= 1;
                @(posedge I_CLK);
                I_SPAN_DONE <= 0;
                repeat (2) @(posedge I_CLK);
                I_SPAN_DONE <= 1;
                I_LAST_SPAN <= 1;
                @(posedge I_CLK);
                I_SPAN_DONE <= 0;
                I_LAST_SPAN <= 0;
            end
            if (!eng_no_done) begin
                repeat (4) @(posedge I_CLK);
                I_TEST_DONE <= 1;
                @(posedge I_CLK);
                I_TEST_DONE <= 0;
            end
        end
        if (O_SAVE_REQ === 1'b1) begin
            repeat (3) @(posedge I_CLK);
            I_SAVE_DONE <= 1;
            @(posedge I_CLK);
            I_SAVE_DONE <= 0;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge I_CLK);
        PENABLE <= 1;
        do @(posedge I_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        #1;
    endtask
    task automatic print_verdict;
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge I_CLK);
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge I_CLK);
        I_SYS_RST <= 0;
        repeat (2) @(posedge I_CLK);
        #1;
        check("health_rst", O_HEALTH_EN, 1);
        for (int i = 0; i < 14; i++) begin
            kind_seen = SASTC_T_NONE;
            host.issue(rows[i].f, rows[i].s, rows[i].l, ok);
            #1;
            check("done", ok, 1);
            check("err", O_ERR, rows[i].er);
            check("autosave", O_AUTOSAVE_EN, rows[i].as);
            if (rows[i].k != SASTC_T_NONE) check("kind", kind_seen, rows[i].k);
            repeat (20) @(posedge I_CLK);
        end
        apb(0, `SASTC_ADDR_CTRL, 0);
        check("ctrl", rd, 32'h00000001);
        apb(1, `SASTC_ADDR_CTRL, 32'h00000003);
        check("apb_as", O_AUTOSAVE_EN, 1);
        apb(1, `SASTC_ADDR_CTRL, 32'h00000002);
        check("apb_forced", O_AUTOSAVE_EN, 0);
        apb(1, `SASTC_ADDR_CTRL, 32'h00000001);
        apb(0, 12'h008, 0);
        check("unmapped", er, 1);
        host.issue(8'hD2, 8'hF1, 8'h00, ok);
        host.issue(8'hD9, 8'h00, 8'h00, ok);
        #1;
        check("health_off", O_HEALTH_EN, 0);
        check("as_off", O_AUTOSAVE_EN, 0);
        host.issue(8'hD2, 8'hF1, 8'h00, ok);
        #1;
        check("refused", O_ERR, 1);
        host.issue(8'hD8, 8'h00, 8'h00, ok);
        host.issue(8'hD2, 8'hF1, 8'h00, ok);
        save_seen = 0;
        I_ACTIVE_IDLE <= 1;
        repeat (20) @(posedge I_CLK);
        check("idle_save", save_seen, 1);
        host.issue(8'hD2, 8'h00, 8'h00, ok);
        I_POWER_EVENT <= 1;
        repeat (20) @(posedge I_CLK);
        check("power_save", save_seen, 2);
        I_TEST_FAIL <= 1;
        host.issue(8'hD4, 8'h00, 8'h81, ok);
        #1;
        check("lba_low", O_LBA_LOW, 8'hF4);
        check("lba_high", O_LBA_HIGH, 8'h2C);
        check("abrt", O_ABRT, 1);
        @(posedge I_CLK);
        I_TEST_FAIL <= 0;
        eng_hold = 1;
        for (int k = 0; k < 2; k++) begin
            host.issue(8'hD4, 8'h00, 8'h02, ok);
            host.issue(8'hD4, 8'h00, abort_codes[k], ok);
            #1;
            check("abort", abort_seen, k + 1);
        end
        eng_hold = 0;
        eng_no_done = 1;
        @(posedge I_CLK);
        I_OFFLINE_FLAG <= 1;
        host.issue(8'hD4, 8'h00, 8'h04, ok);
        repeat (20) @(posedge I_CLK);
        #1;
        check("pending", {O_PENDING, O_ACTIVE}, 2'b11);
        check("span", O_SPAN_UNDER_TEST, `SASTC_SPAN_OFFLINE);
        check("st", {O_SELFTEST_STATUS, O_OFFLINE_STATUS}, 16'h0003);
        host.issue(8'hD3, 8'h00, 8'h00, ok);
        check("served", {ok, O_DRDY}, 2'b11);
        I_OFFLINE_FLAG <= 0;
        eng_no_done = 0;
        I_NV_AUTOSAVE <= 1;
        I_NV_PENDING <= 1;
        I_SYS_RST <= 1;
        repeat (3) @(posedge I_CLK);
        I_SYS_RST <= 0;
        repeat (2) @(posedge I_CLK);
        #1;
        check("nv_as", O_AUTOSAVE_EN, 1);
        check("wait", {O_PENDING, O_ACTIVE}, 2'b10);
        @(posedge I_CLK);
        I_PENDING_EXPIRED <= 1;
        @(posedge I_CLK);
        I_PENDING_EXPIRED <= 0;
        I_HOST_RESET <= 1;
        @(posedge I_CLK);
        I_HOST_RESET <= 0;
        repeat (3) @(posedge I_CLK);
        #1;
        check("resume", {O_PENDING, O_ACTIVE}, 2'b11);
        @(posedge I_CLK);
        I_MEDIA_DONE <= 1;
        @(posedge I_CLK);
        I_MEDIA_DONE <= 0;
        repeat (3) @(posedge I_CLK);
        #1;
        check("scan_end", {O_PENDING, O_ACTIVE, O_OFFLINE_STATUS}, 10'h002);
        print_verdict;
    end
endmodule // test_smart_autosave_selftest_control
bind sastc_top sastc_props u_props (.*);
`default_nettype wire
